// >>> design/smts_pkg.sv
// Shared constants for the sync monitor, timestamp and overrange block.
// Assumes one sampling clock and an 8-bit register map with 12-bit
// addresses, reached through the device's serial register port.
package smts_pkg;

  // Data path widths and latencies in sampling clock cycles
  localparam int          DATA_W       = 14;
  localparam int          DATA_LAT_CYC = 43;  // Sample in to delay line out
  localparam int          TS_LAT_CYC   = 8;   // Sync capture to marker out
  localparam int          TS_LEAD_CYC  = DATA_LAT_CYC - TS_LAT_CYC;

  // Sync monitor tap grid, in picoseconds around the rising clock edge
  localparam int          WIN_LEAD_PS      = -60;
  localparam int          WIN_LAG_PS       = 140;
  localparam int          TAP_STEP_PS      = 40;
  localparam int          SAMPLE_OFFSET_PS = 60;
  localparam int          TAP_COUNT =
    (WIN_LAG_PS - WIN_LEAD_PS) / TAP_STEP_PS + 1;
  localparam int          WIN_COUNT = TAP_COUNT - 1;
  localparam int          CAPTURE_TAP =
    (SAMPLE_OFFSET_PS - WIN_LEAD_PS) / TAP_STEP_PS;

  // Register addresses
  localparam logic [11:0] ADDR_OVR_CFG_A = 12'h10a;
  localparam logic [11:0] ADDR_OVR_CFG_B = 12'h10b;
  localparam logic [11:0] ADDR_LSB_OVR   = 12'h116;
  localparam logic [11:0] ADDR_FREQ_RNG  = 12'h132;
  localparam logic [11:0] ADDR_SYNC_STAT = 12'h140;
  localparam logic [11:0] ADDR_PIN_CFG   = 12'h146;
  localparam logic [11:0] ADDR_TS_CFG    = 12'h162;
  localparam logic [11:0] ADDR_DEC_CFG   = 12'h169;
  localparam logic [11:0] ADDR_NYQ_ZONE  = 12'h16b;
  localparam logic [11:0] ADDR_SYNC_MASK = 12'h170;

  // Reset values
  localparam logic [7:0]  OVR_CFG_RST   = 8'h01;
  localparam logic [7:0]  LSB_OVR_RST   = 8'h00;
  localparam logic [7:0]  FREQ_RNG_RST  = 8'h00;
  localparam logic [7:0]  PIN_CFG_RST   = 8'h01;
  localparam logic [7:0]  TS_CFG_RST    = 8'h00;
  localparam logic [7:0]  DEC_CFG_RST   = 8'h00;
  localparam logic [7:0]  NYQ_ZONE_RST  = 8'h00;  // First zone
  localparam logic [7:0]  SYNC_MASK_RST = 8'h07;
  localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

  // Field positions and codes
  localparam int          PIN0_FN_LSB   = 0;      // Pin zero function [1:0]
  localparam logic [1:0]  PIN0_FN_SYNC  = 2'h0;
  localparam int          OVR_OR_BIT    = 2;      // 1: both channels OR-ed
  localparam int          TS_EN_LSB     = 6;      // Timestamp field [7:6]
  localparam logic [1:0]  TS_EN_CODE    = 2'h3;
  localparam int          LSB_OVR_BIT   = 0;
  localparam int          OVR_PIN_BIT   = 0;
  localparam int          DEC_FIELD_W   = 4;      // Nonzero: decimation
  localparam int          MASK_DIV_BIT  = 0;
  localparam int          MASK_OSC_BIT  = 1;
  localparam int          MASK_RAMP_BIT = 2;
  localparam int          ST_SEEN_BIT   = 6;
  localparam int          ST_COMB_BIT   = 5;

  // Code limits of the signed converter word
  localparam logic [13:0] CODE_MAX = 14'h1fff;
  localparam logic [13:0] CODE_MIN = 14'h2000;
  localparam int          DEC_PHASE_W = 4;

endpackage : smts_pkg

// >>> design/smts_window_classify.sv
// Sorts a sync reference transition into one of five timing windows.
// Assumes the taps are registered copies of the sync reference taken at
// evenly spaced delays from earliest (bit 0) to latest.
`timescale 1ns/10ps

module smts_window_classify (
  input  wire logic [smts_pkg::TAP_COUNT-1:0] taps,      // Sampled taps
  output logic      [smts_pkg::WIN_COUNT-1:0] win_flags, // One-hot window
  output logic                                win_any    // Any window hit
);

  logic [smts_pkg::WIN_COUNT-1:0] pair_diff;  // Transition between taps

  // One comparator per adjacent pair of taps
  genvar g;
  generate
    for (g = 0; g < smts_pkg::WIN_COUNT; g++) begin : g_pair
      assign pair_diff[g] = taps[g] ^ taps[g+1];
    end
  endgenerate

  // Earliest window wins so that only one flag is ever raised;
  // a glitch spanning several pairs still reports a single window
  always_comb begin
    win_flags = '0;
    for (int i = smts_pkg::WIN_COUNT - 1; i >= 0; i--) begin
      if (pair_diff[i]) begin
        win_flags    = '0;
        win_flags[i] = 1'b1;
      end
    end
    win_any = |pair_diff;
  end

endmodule : smts_window_classify

// >>> design/smts_delay_line.sv
// Fixed-length delay line for sample words and marker bits.
// Assumes one clock; every stage shifts on every edge.
`timescale 1ns/10ps

module smts_delay_line #(
  parameter int WIDTH = 1,  // Word width
  parameter int DEPTH = 1   // Number of stages
) (
  input  wire logic             sys_clk,  // Sampling clock
  input  wire logic             nrst,     // Async reset, active low
  input  wire logic [WIDTH-1:0] din,      // Word entering
  output logic      [WIDTH-1:0] dout      // Word after DEPTH edges
);

  logic [WIDTH-1:0] stage [DEPTH];  // Shift storage

  // Plain shift chain; storage held in flops since depth is small
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign dout = stage[DEPTH-1];

endmodule : smts_delay_line

// >>> design/smts_top.sv
// Sync monitor, timestamp marker and overrange flagging of the converter.
// Assumes converter and downconverter words arrive once per sampling
// clock, and that the serial register port is decoded into a parallel
// strobe with address and data before it reaches this block.
`timescale 1ns/10ps

// How it works
// - Sync sampled each clock edge, 60 ps late
// - Monitor watches -60 ps to +140 ps
// - At most one of five window flags
// - Monitor status updates on each sync edge
// - Edge-seen bit sticks until software clears
// - Status register at 0x140, bit 7 zero
// - Decimation mode: sync resets divider, oscillator phase
// - Bypass mode: sync restarts ramp pattern
// - Masks choose which blocks sync resets
// - Timestamp captures sync rise on clock edge
// - Marker replaces LSB of output lane two
// - Marker after 8 cycles, data after 44
// - Overrange when input hits maximum or minimum code
// - Overrange latency not above bypass data latency
// - Overrange on per-channel or OR-ed pin
// - Overrange can replace each channel LSB
// - Overrange output configured at 0x10A, 0x10B
// - Nyquist zone defaults first; frequency range settable
module smts_top (
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  input  wire logic [smts_pkg::TAP_COUNT-1:0]    sync_taps,
  input  wire logic [smts_pkg::DATA_W-1:0]       adc_a_data,
  input  wire logic [smts_pkg::DATA_W-1:0]       adc_b_data,
  input  wire logic [smts_pkg::DATA_W-1:0]       ddc_a_data,
  input  wire logic [smts_pkg::DATA_W-1:0]       ddc_b_data,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [11:0]                       reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  output logic      [7:0]                        reg_rdata,
  output logic      [smts_pkg::DATA_W-1:0]       out_a,
  output logic      [smts_pkg::DATA_W-1:0]       out_b,
  output logic                                   ovr_pin_one,
  output logic                                   ovr_pin_two,
  output logic                                   divider_reset,
  output logic                                   osc_phase_reset,
  output logic                                   ramp_restart,
  output logic      [smts_pkg::DATA_W-1:0]       ramp_value,
  output logic      [smts_pkg::DEC_PHASE_W-1:0]  dec_phase,
  output logic      [7:0]                        nyquist_zone,
  output logic      [7:0]                        freq_range
);

  localparam int DW = smts_pkg::DATA_W;

  // Configuration registers
  logic [7:0]  ovr_cfg_a_reg;     // Overrange pin setup, channel A
  logic [7:0]  ovr_cfg_b_reg;     // Overrange pin setup, channel B
  logic [7:0]  lsb_ovr_reg;       // Overrange in data LSB
  logic [7:0]  pin_cfg_reg;       // General pin function select
  logic [7:0]  ts_cfg_reg;        // Timestamp enable
  logic [7:0]  dec_cfg_reg;       // Common decimation factor
  logic [7:0]  sync_mask_reg;     // Blocks reset by sync
  logic [7:0]  status_reg;        // Monitor status
  logic [smts_pkg::TAP_COUNT-1:0] tap_reg;  // Registered sync taps
  logic        samp_prev_reg;     // Previous capture sample
  logic        late_prev_reg;     // Previous latest-tap sample

  // Decoded controls
  logic        sync_sel;          // Pin zero serves as sync input
  logic        ts_on;             // Timestamp replaces lane two LSB
  logic        dec_mode;          // Decimation path active
  logic        ref_edge;          // Rising edge of sync reference
  logic        mon_edge;          // Sync rise seen by the monitor
  logic        stat_clr;          // Software clears edge-seen
  logic [smts_pkg::WIN_COUNT-1:0] win_flags;  // Classified window
  logic        win_any;           // A transition fell in the window

  // Delay line payloads
  logic [2*DW+1:0] dly_in;        // Both words plus both overrange bits
  logic [2*DW+1:0] dly_out;       // Same, 43 edges later
  logic        ovr_a_now;         // Channel A at a code limit
  logic        ovr_b_now;         // Channel B at a code limit
  logic        ovr_a_dly;         // Delayed overrange A
  logic        ovr_b_dly;         // Delayed overrange B
  logic        ts_mark_dly;       // Delayed timestamp marker

  // Zero in bits [1:0] selects pin zero as sync; other codes disable it
  assign sync_sel = pin_cfg_reg[smts_pkg::PIN0_FN_LSB +: 2]
                    == smts_pkg::PIN0_FN_SYNC;
  assign ts_on    = ts_cfg_reg[smts_pkg::TS_EN_LSB +: 2]
                    == smts_pkg::TS_EN_CODE;
  assign dec_mode = |dec_cfg_reg[smts_pkg::DEC_FIELD_W-1:0];
  assign stat_clr = reg_wr && (reg_addr == smts_pkg::ADDR_SYNC_STAT)
                    && reg_wdata[smts_pkg::ST_SEEN_BIT];

  // Edge of the sample taken at the capture tap; one pulse is enough
  assign ref_edge = sync_sel && tap_reg[smts_pkg::CAPTURE_TAP]
                    && !samp_prev_reg;

  // Monitor edge from the latest tap, so rises after the capture tap
  // still land in windows four and five
  assign mon_edge = sync_sel && tap_reg[smts_pkg::TAP_COUNT-1]
                    && !late_prev_reg;

  // Register taps on each rising clock edge; the capture tap sits
  // 60 ps after the edge, so a source aligned to the falling edge
  // gets the widest margin on both sides
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tap_reg       <= '0;
      samp_prev_reg <= 1'b0;
      late_prev_reg <= 1'b0;
    end else begin
      tap_reg       <= sync_taps;
      samp_prev_reg <= tap_reg[smts_pkg::CAPTURE_TAP];
      late_prev_reg <= tap_reg[smts_pkg::TAP_COUNT-1];
    end
  end

  // Window classification of the registered taps
  smts_window_classify u_classify (
    .taps      (tap_reg),
    .win_flags (win_flags),
    .win_any   (win_any)
  );

  // Monitor status; set of edge-seen wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= 8'h00;
    end else begin
      if (mon_edge) begin
        // Window flags are not sticky: each edge overwrites them
        status_reg[smts_pkg::WIN_COUNT-1:0] <= win_flags;
        status_reg[smts_pkg::ST_COMB_BIT]   <= win_any;
        status_reg[smts_pkg::ST_SEEN_BIT]   <= 1'b1;
      end else if (stat_clr) begin
        status_reg[smts_pkg::ST_SEEN_BIT]   <= 1'b0;
      end
      status_reg[7] <= 1'b0;
    end
  end

  // Configuration writes; the status register is only cleared above
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ovr_cfg_a_reg <= smts_pkg::OVR_CFG_RST;
      ovr_cfg_b_reg <= smts_pkg::OVR_CFG_RST;
      lsb_ovr_reg   <= smts_pkg::LSB_OVR_RST;
      freq_range    <= smts_pkg::FREQ_RNG_RST;
      pin_cfg_reg   <= smts_pkg::PIN_CFG_RST;
      ts_cfg_reg    <= smts_pkg::TS_CFG_RST;
      dec_cfg_reg   <= smts_pkg::DEC_CFG_RST;
      nyquist_zone  <= smts_pkg::NYQ_ZONE_RST;
      sync_mask_reg <= smts_pkg::SYNC_MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        smts_pkg::ADDR_OVR_CFG_A: ovr_cfg_a_reg <= reg_wdata;
        smts_pkg::ADDR_OVR_CFG_B: ovr_cfg_b_reg <= reg_wdata;
        smts_pkg::ADDR_LSB_OVR:   lsb_ovr_reg   <= reg_wdata;
        smts_pkg::ADDR_FREQ_RNG:  freq_range    <= reg_wdata;
        smts_pkg::ADDR_PIN_CFG:   pin_cfg_reg   <= reg_wdata;
        smts_pkg::ADDR_TS_CFG:    ts_cfg_reg    <= reg_wdata;
        smts_pkg::ADDR_DEC_CFG:   dec_cfg_reg   <= reg_wdata;
        smts_pkg::ADDR_NYQ_ZONE:  nyquist_zone  <= reg_wdata;
        smts_pkg::ADDR_SYNC_MASK: sync_mask_reg <= reg_wdata;
        default: ;  // Unmapped and read-only addresses ignore writes
      endcase
    end
  end

  // Read data one edge after the read strobe; unmapped reads as zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        smts_pkg::ADDR_OVR_CFG_A: reg_rdata <= ovr_cfg_a_reg;
        smts_pkg::ADDR_OVR_CFG_B: reg_rdata <= ovr_cfg_b_reg;
        smts_pkg::ADDR_LSB_OVR:   reg_rdata <= lsb_ovr_reg;
        smts_pkg::ADDR_FREQ_RNG:  reg_rdata <= freq_range;
        smts_pkg::ADDR_SYNC_STAT: reg_rdata <= status_reg;
        smts_pkg::ADDR_PIN_CFG:   reg_rdata <= pin_cfg_reg;
        smts_pkg::ADDR_TS_CFG:    reg_rdata <= ts_cfg_reg;
        smts_pkg::ADDR_DEC_CFG:   reg_rdata <= dec_cfg_reg;
        smts_pkg::ADDR_NYQ_ZONE:  reg_rdata <= nyquist_zone;
        smts_pkg::ADDR_SYNC_MASK: reg_rdata <= sync_mask_reg;
        default:                  reg_rdata <= smts_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // Decimation state reset; phase counter stands in for the dividers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      divider_reset   <= 1'b0;
      osc_phase_reset <= 1'b0;
      dec_phase       <= '0;
    end else begin
      divider_reset   <= ref_edge && dec_mode
                         && sync_mask_reg[smts_pkg::MASK_DIV_BIT];
      osc_phase_reset <= ref_edge && dec_mode
                         && sync_mask_reg[smts_pkg::MASK_OSC_BIT];
      if (ref_edge && dec_mode && sync_mask_reg[smts_pkg::MASK_DIV_BIT]) begin
        dec_phase <= '0;
      end else begin
        dec_phase <= dec_phase + 1'b1;
      end
    end
  end

  // Ramp pattern; bypass latency is already fixed, so sync only
  // restarts the ramp there
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_restart <= 1'b0;
      ramp_value   <= '0;
    end else begin
      ramp_restart <= ref_edge && !dec_mode
                      && sync_mask_reg[smts_pkg::MASK_RAMP_BIT];
      if (ref_edge && !dec_mode
          && sync_mask_reg[smts_pkg::MASK_RAMP_BIT]) begin
        ramp_value <= '0;
      end else begin
        ramp_value <= ramp_value + 1'b1;
      end
    end
  end

  // Overrange: input sitting at either end of the code range
  assign ovr_a_now = (adc_a_data == smts_pkg::CODE_MAX)
                     || (adc_a_data == smts_pkg::CODE_MIN);
  assign ovr_b_now = (adc_b_data == smts_pkg::CODE_MAX)
                     || (adc_b_data == smts_pkg::CODE_MIN);
  assign dly_in    = {ovr_b_now, ovr_a_now, adc_b_data, adc_a_data};

  // Flags share the data delay, so their latency equals the bypass data's
  smts_delay_line #(
    .WIDTH (2*DW+2),
    .DEPTH (smts_pkg::DATA_LAT_CYC)
  ) u_data_dly (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .din     (dly_in),
    .dout    (dly_out)
  );

  assign ovr_a_dly = dly_out[2*DW];
  assign ovr_b_dly = dly_out[2*DW+1];

  // Marker path is much shorter than the data path and is not aligned
  smts_delay_line #(
    .WIDTH (1),
    .DEPTH (smts_pkg::TS_LAT_CYC - 1)
  ) u_ts_dly (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .din     (ref_edge && ts_on),
    .dout    (ts_mark_dly)
  );

  // Output words; decimation mode carries the downconverter streams
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_a <= '0;
      out_b <= '0;
    end else begin
      if (dec_mode) begin
        out_a <= ddc_a_data;
        out_b <= ddc_b_data;
      end else begin
        out_a <= dly_out[DW-1:0];
        out_b <= dly_out[2*DW-1:DW];
      end
      // Overrange flag in the LSB of either stream
      if (lsb_ovr_reg[smts_pkg::LSB_OVR_BIT]) begin
        out_a[0] <= ovr_a_dly;
        out_b[0] <= ovr_b_dly;
      end
      // Marker has priority over overrange on the lane two LSB
      if (ts_on) begin
        out_a[0] <= ts_mark_dly;
      end
    end
  end

  // Overrange pins: per channel, or both channels OR-ed on pin one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ovr_pin_one <= 1'b0;
      ovr_pin_two <= 1'b0;
    end else if (pin_cfg_reg[smts_pkg::OVR_OR_BIT]) begin
      ovr_pin_one <= (ovr_a_dly && ovr_cfg_a_reg[smts_pkg::OVR_PIN_BIT])
                     || (ovr_b_dly
                         && ovr_cfg_b_reg[smts_pkg::OVR_PIN_BIT]);
      ovr_pin_two <= 1'b0;
    end else begin
      ovr_pin_one <= ovr_a_dly && ovr_cfg_a_reg[smts_pkg::OVR_PIN_BIT];
      ovr_pin_two <= ovr_b_dly && ovr_cfg_b_reg[smts_pkg::OVR_PIN_BIT];
    end
  end

  // Checks on monitor, marker, overrange and sync resets
  property p_seen_set;
    @(posedge sys_clk) disable iff (!nrst)
    mon_edge |=> status_reg[smts_pkg::ST_SEEN_BIT];
  endproperty
  a_seen_set: assert property (p_seen_set)
    else $error("edge-seen not set after sync edge");

  property p_seen_hold;
    @(posedge sys_clk) disable iff (!nrst)
    status_reg[smts_pkg::ST_SEEN_BIT] && !stat_clr
    |=> status_reg[smts_pkg::ST_SEEN_BIT];
  endproperty
  a_seen_hold: assert property (p_seen_hold)
    else $error("edge-seen dropped without a clear");

  property p_onehot;
    @(posedge sys_clk) disable iff (!nrst)
    mon_edge && win_any |=> $onehot(status_reg[smts_pkg::WIN_COUNT-1:0]);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("window flags not one-hot");

  property p_comb;
    @(posedge sys_clk) disable iff (!nrst)
    (status_reg[smts_pkg::ST_COMB_BIT] == |status_reg[4:0])
    && !status_reg[7];
  endproperty
  a_comb: assert property (p_comb)
    else $error("status layout broken");

  property p_update;
    @(posedge sys_clk) disable iff (!nrst)
    !mon_edge |=> $stable(status_reg[smts_pkg::ST_COMB_BIT:0]);
  endproperty
  a_update: assert property (p_update)
    else $error("window flags changed without sync edge");

  property p_ts_lat;
    @(posedge sys_clk) disable iff (!nrst)
    ref_edge && ts_on |-> ##8 (out_a[0] || !ts_on);
  endproperty
  a_ts_lat: assert property (p_ts_lat)
    else $error("timestamp marker late or missing");

  property p_ovr_lat;
    @(posedge sys_clk) disable iff (!nrst)
    (adc_a_data == smts_pkg::CODE_MAX)
    && ovr_cfg_a_reg[smts_pkg::OVR_PIN_BIT]
    |-> ##44 (ovr_pin_one || !ovr_cfg_a_reg[smts_pkg::OVR_PIN_BIT]);
  endproperty
  a_ovr_lat: assert property (p_ovr_lat)
    else $error("overrange pin late or missing");

  property p_dec_reset;
    @(posedge sys_clk) disable iff (!nrst)
    ref_edge && dec_mode && sync_mask_reg[smts_pkg::MASK_DIV_BIT]
    |=> divider_reset && (dec_phase == '0);
  endproperty
  a_dec_reset: assert property (p_dec_reset)
    else $error("decimation state not reset by sync");

  property p_ramp;
    @(posedge sys_clk) disable iff (!nrst)
    ref_edge && !dec_mode && sync_mask_reg[smts_pkg::MASK_RAMP_BIT]
    |=> ramp_restart && (ramp_value == '0);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp not restarted by sync");

endmodule : smts_top

// >>> bench/smts_sync_src.sv
// Sync reference source model driving the monitor's sampled taps.
// Assumes tap bit 0 is the earliest sample; the line idles low.
`timescale 1ns/10ps

module smts_sync_src (
  input  wire logic                           sys_clk,   // Sampling clock
  output logic      [smts_pkg::TAP_COUNT-1:0] sync_taps  // Sampled sync
);
  initial sync_taps = 6'h00;  // Idle low between pulses

  // Single pulse; pattern shows where the rise lands in the window
  task automatic pulse(input logic [5:0] p);
    @(posedge sys_clk);
    #1 sync_taps = p;
    @(posedge sys_clk);
    #1 sync_taps = 6'h00;  // Low again, so the next rise is seen
  endtask : pulse
endmodule : smts_sync_src

// >>> bench/smts_top_tb_top.sv
// Bench for sync monitor, timestamp marker and overrange flagging.
// Assumes the sync source model drives the taps, the bench the rest.
`timescale 1ns/10ps

module smts_top_tb_top;
  logic        sys_clk, nrst, reg_wr, reg_rd;  // Clock, reset, strobes
  logic [11:0] reg_addr;                       // Register address
  logic [7:0]  reg_wdata, reg_rdata, nz, fr;   // Register data
  logic [13:0] a, b, out_a, out_b, rvl;        // Sample words, ramp
  logic [5:0]  taps, p;                        // Sync taps, pattern
  logic        op1, op2, dr, opr, rr, orm, lsbm, dm; // Pins, pulses, modes
  logic [3:0]  dph;                            // Divider phase
  logic [13:0] qa[$], qb[$];                   // Words in flight
  int          bad_count, samples_checked, seed, i, k;
  // Address and reset value pairs
  localparam logic [19:0] RST_TAB [5] =
    '{20'h14601, 20'h17007, 20'h16b00, 20'h10a01, 20'h3ff00};

  smts_sync_src smts_sync_src_i (.sys_clk(sys_clk), .sync_taps(taps));
  smts_top smts_top_i (.sys_clk(sys_clk), .nrst(nrst), .sync_taps(taps),
    .adc_a_data(a), .adc_b_data(b), .ddc_a_data(a), .ddc_b_data(b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .out_a(out_a),
    .out_b(out_b), .ovr_pin_one(op1), .ovr_pin_two(op2),
    .divider_reset(dr), .osc_phase_reset(opr), .ramp_restart(rr),
    .ramp_value(rvl), .dec_phase(dph), .nyquist_zone(nz),
    .freq_range(fr));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Expected overrange of one word
  function automatic logic overrange_flag(input logic [13:0] w);
    return w == smts_pkg::CODE_MAX || w == smts_pkg::CODE_MIN;
  endfunction : overrange_flag

  // Expected output word, LSB swapped for overrange of word o if enabled
  function automatic logic [13:0] xw(input logic [13:0] w,
                                     input logic [13:0] o);
    return lsbm ? {w[13:1], overrange_flag(o)} : w;
  endfunction : xw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = d;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rdc(input logic [11:0] ad, input logic [7:0] exp);
    @(posedge sys_clk);
    #1 reg_rd = 1'b1;
    reg_addr = ad;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    chk({8'h0, reg_rdata}, {8'h0, exp});
  endtask : rdc

  // Pulse, then stand one edge after capture, where pulses show
  task automatic syn(input logic [5:0] pt);
    smts_sync_src_i.pulse(pt);
    @(posedge sys_clk);
    #1;
  endtask : syn

  task automatic end_of_test;
    $display("Checked %0d, bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  // Watchdog so a hang still reaches the verdict
  initial begin
    #800000;
    bad_count++;
    end_of_test();
  end

  initial begin
    seed = 32'h742c6df5;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, a, b} = '0;
    repeat (20) @(posedge sys_clk);
    #1 nrst = 1'b1;
    for (i = 0; i < 5; i++) rdc(RST_TAB[i][19:8], RST_TAB[i][7:0]);
    chk({8'h0, nz}, 16'h0);
    wr(12'h132, 8'ha5);
    chk({8'h0, fr}, 16'h00a5);
    syn(6'h3f);  // Pin zero not yet sync, so ignored
    rdc(12'h140, 8'h00);
    wr(12'h146, 8'h00);
    // Walk the rise across all five windows
    for (i = 0; i < 5; i++) begin
      p = 6'h3f;
      p = p << (i + 1);
      syn(p);
      // Late rises fall after the capture tap of a one-cycle pulse
      chk({14'h0, rr, rvl == 14'h0}, i < 3 ? 16'h3 : 16'h0);
      rdc(12'h140, 8'h60 | (8'h01 << i));
    end
    syn(6'h3f);
    rdc(12'h140, 8'h40);
    wr(12'h140, 8'h40);
    rdc(12'h140, 8'h00);
    // Decimation mode, full mask then oscillator only
    wr(12'h169, 8'h01);
    for (i = 0; i < 2; i++) begin
      wr(12'h170, i ? 8'h02 : 8'h07);
      syn(6'h3f);
      chk({13'h0, dr, opr, dr ? dph == 4'h0 : 1'b1}, i ? 3 : 7);
    end
    wr(12'h169, 8'h00);
    wr(12'h162, 8'hc0);
    smts_sync_src_i.pulse(6'h3f);
    repeat (7) @(posedge sys_clk);
    #1 chk({15'h0, out_a[0]}, 16'h0);
    @(posedge sys_clk);
    #1 chk({15'h0, out_a[0]}, 16'h1);
    wr(12'h162, 8'h00);
    // Random words, per-channel pins, OR-ed pin, LSB flagging, decimation
    for (k = 0; k < 4; k++) begin
      orm = k > 0;
      lsbm = k > 1;
      dm = k > 2;
      wr(12'h146, {5'h0, orm, 2'h0});
      wr(12'h116, {7'h0, lsbm});
      wr(12'h169, {7'h0, dm});
      qa.delete();
      qb.delete();
      repeat (200) begin
        @(posedge sys_clk);
        #1;
        if (qa.size() == 44) begin
          // Decimation words pass one edge; flags keep the data delay
          chk({2'h0, out_a},
              {2'h0, xw(dm ? qa[43] : qa[0], qa[0])});
          chk({2'h0, out_b},
              {2'h0, xw(dm ? qb[43] : qb[0], qb[0])});
          chk({14'h0, op1, op2}, orm ? {14'h0, overrange_flag(qa[0]) | overrange_flag(qb[0]),
            1'b0} : {14'h0, overrange_flag(qa[0]), overrange_flag(qb[0])});
          void'(qa.pop_front());
          void'(qb.pop_front());
        end
        a = 14'($random(seed));
        b = 14'($random(seed));
        if (a[2:0] == 3'h0) a = a[3] ? smts_pkg::CODE_MAX : smts_pkg::CODE_MIN;
        if (b[2:0] == 3'h1) b = smts_pkg::CODE_MAX;
        qa.push_back(a);
        qb.push_back(b);
      end
    end
    end_of_test();
  end
endmodule : smts_top_tb_top
